// *** hw/crossbar_peripheral_route_enables.sv ***
// Priority crossbar route-enable logic: SFRs, pin allocation, pin muxing.
// Assumes peripherals on the system clock and pad logic outside.
`timescale 1ns/1ps
`default_nettype none
`include "route_defines.svh"

module crossbar_peripheral_route_enables (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// SFR bus
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	output logic [7:0] sfrRdData,
	// Configuration from neighbouring registers
	input wire logic globalRouteEnable,
	input wire logic [`PIN_COUNT-1:0] pinSkipMask,
	input wire logic spiAFourWire,
	input wire logic spiBFourWire,
	// Peripheral side, one bit per function slot
	input wire logic [`SLOT_COUNT-1:0] slotOut,
	input wire logic [`SLOT_COUNT-1:0] slotOutEn,
	output logic [`SLOT_COUNT-1:0] slotIn,
	output logic [`SLOT_COUNT-1:0] slotRouted,
	// Port pins
	input wire logic [`PIN_COUNT-1:0] pinIn,
	output logic [`PIN_COUNT-1:0] pinOut,
	output logic [`PIN_COUNT-1:0] pinOutEn,
	output logic [`PIN_COUNT-1:0] pinOpenDrain
);
	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] routeEnableLow;
	logic [7:0] routeEnableHigh;

	route_regs u_regs (
		.clk(clk),
		.rst_n(rst_n),
		.sfrAddr(sfrAddr),
		.sfrWrData(sfrWrData),
		.sfrWrEn(sfrWrEn),
		.sfrRdEn(sfrRdEn),
		.sfrRdData(sfrRdData),
		.routeEnableLow(routeEnableLow),
		.routeEnableHigh(routeEnableHigh)
	);

	// ****************************************
	// Wanted functions
	// ****************************************
	logic [`SLOT_COUNT-1:0] want;
	logic [2:0] capCount;

	assign capCount = routeEnableHigh[`CAP_COUNT_MSB:`CAP_COUNT_LSB];

	always_comb begin
		want = '0;
		want[`SLOT_TX] = routeEnableLow[`BIT_ASYNC_SERIAL];
		want[`SLOT_RX] = routeEnableLow[`BIT_ASYNC_SERIAL];
		want[`SLOT_SPI_B_SCK] = routeEnableHigh[`BIT_SPI_B];
		want[`SLOT_SPI_B_MISO] = routeEnableHigh[`BIT_SPI_B];
		want[`SLOT_SPI_B_MOSI] = routeEnableHigh[`BIT_SPI_B];
		want[`SLOT_SPI_B_SEL] = routeEnableHigh[`BIT_SPI_B] && spiBFourWire;
		want[`SLOT_SPI_A_SCK] = routeEnableLow[`BIT_SPI_A];
		want[`SLOT_SPI_A_MISO] = routeEnableLow[`BIT_SPI_A];
		want[`SLOT_SPI_A_MOSI] = routeEnableLow[`BIT_SPI_A];
		want[`SLOT_SPI_A_SEL] = routeEnableLow[`BIT_SPI_A] && spiAFourWire;
		want[`SLOT_SDA] = routeEnableLow[`BIT_TWOWIRE];
		want[`SLOT_SCL] = routeEnableLow[`BIT_TWOWIRE];
		want[`SLOT_CMP_A_SYNC] = routeEnableLow[`BIT_CMP_A_SYNC];
		want[`SLOT_CMP_A_ASYNC] = routeEnableLow[`BIT_CMP_A_ASYNC];
		want[`SLOT_CMP_B_SYNC] = routeEnableLow[`BIT_CMP_B_SYNC];
		want[`SLOT_CMP_B_ASYNC] = routeEnableLow[`BIT_CMP_B_ASYNC];
		want[`SLOT_SYS_CLOCK] = routeEnableLow[`BIT_SYS_CLOCK];
		// Reserved count routes nothing
		for (int k = 0; k < `CAP_MODULES; k++) begin
			want[`SLOT_CAP0 + k] = (capCount != `CAP_COUNT_RESERVED) && (capCount > 3'(k));
		end
		want[`SLOT_COUNTER_EXT] = routeEnableHigh[`BIT_COUNTER_EXT];
		want[`SLOT_TIMER_A] = routeEnableHigh[`BIT_TIMER_A];
		want[`SLOT_TIMER_B] = routeEnableHigh[`BIT_TIMER_B];
	end

	// ****************************************
	// Pin allocation
	// ****************************************
	// Plain combinational walk; long chain but only a few dozen cells deep
	logic [`PIN_COUNT-1:0] nxt_mapValid;
	route_pkg::slot_idx_t nxt_mapSlot [`PIN_COUNT];

	always_comb begin
		logic [`PIN_COUNT-1:0] taken;
		logic found;
		taken = '0;
		found = 1'b0;
		for (int p = 0; p < `PIN_COUNT; p++) begin
			nxt_mapSlot[p] = '0;
		end
		// Fixed locations first, regardless of skip bits
		if (want[`SLOT_TX]) begin
			taken[`PIN_SERIAL_TX] = 1'b1;
			nxt_mapSlot[`PIN_SERIAL_TX] = `SLOT_TX;
			taken[`PIN_SERIAL_RX] = 1'b1;
			nxt_mapSlot[`PIN_SERIAL_RX] = `SLOT_RX;
		end
		if (want[`SLOT_SPI_B_SCK]) begin
			taken[`PIN_SPI_B_SCK] = 1'b1;
			nxt_mapSlot[`PIN_SPI_B_SCK] = `SLOT_SPI_B_SCK;
			taken[`PIN_SPI_B_MISO] = 1'b1;
			nxt_mapSlot[`PIN_SPI_B_MISO] = `SLOT_SPI_B_MISO;
			taken[`PIN_SPI_B_MOSI] = 1'b1;
			nxt_mapSlot[`PIN_SPI_B_MOSI] = `SLOT_SPI_B_MOSI;
		end
		if (want[`SLOT_SPI_B_SEL]) begin
			taken[`PIN_SPI_B_SEL] = 1'b1;
			nxt_mapSlot[`PIN_SPI_B_SEL] = `SLOT_SPI_B_SEL;
		end
		// Each later wanted function takes the lowest free pin
		for (int s = `SLOT_FIRST_FLOAT; s < `SLOT_COUNT; s++) begin
			found = 1'b0;
			for (int p = 0; p < `PIN_COUNT; p++) begin
				if (want[s] && !found && !taken[p] && !pinSkipMask[p]) begin
					taken[p] = 1'b1;
					nxt_mapSlot[p] = 5'(s);
					found = 1'b1;
				end
			end
		end
		nxt_mapValid = taken;
	end

	logic [`PIN_COUNT-1:0] mapValid_ff;
	route_pkg::slot_idx_t mapSlot_ff [`PIN_COUNT];

	// Free-running: any register change lands next cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mapValid_ff <= '0;
			for (int p = 0; p < `PIN_COUNT; p++) begin
				mapSlot_ff[p] <= '0;
			end
		end else begin
			mapValid_ff <= nxt_mapValid;
			for (int p = 0; p < `PIN_COUNT; p++) begin
				mapSlot_ff[p] <= nxt_mapSlot[p];
			end
		end
	end

	function automatic logic isSlot(input logic valid, input route_pkg::slot_idx_t got, input int idx);
		isSlot = valid && (got == 5'(idx));
	endfunction

	function automatic logic isTwoWire(input logic valid, input route_pkg::slot_idx_t got);
		isTwoWire = isSlot(valid, got, `SLOT_SDA) || isSlot(valid, got, `SLOT_SCL);
	endfunction

	function automatic logic isBypass(input logic valid, input route_pkg::slot_idx_t got);
		isBypass = isSlot(valid, got, `SLOT_CMP_A_ASYNC) || isSlot(valid, got, `SLOT_CMP_B_ASYNC) ||
			isSlot(valid, got, `SLOT_SYS_CLOCK);
	endfunction

	always_comb begin
		slotRouted = '0;
		for (int p = 0; p < `PIN_COUNT; p++) begin
			if (mapValid_ff[p]) begin
				slotRouted[mapSlot_ff[p]] = 1'b1;
			end
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	logic [`PIN_COUNT-1:0] pinOut_ff;
	logic [`PIN_COUNT-1:0] nxt_pinOut;

	always_comb begin
		for (int p = 0; p < `PIN_COUNT; p++) begin
			nxt_pinOut[p] = mapValid_ff[p] && slotOut[mapSlot_ff[p]];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinOut_ff <= '0;
		end else begin
			pinOut_ff <= nxt_pinOut;
		end
	end

	// Async comparators and clock bypass the flop, else they would be resynchronised
	always_comb begin
		for (int p = 0; p < `PIN_COUNT; p++) begin
			pinOpenDrain[p] = globalRouteEnable && isTwoWire(mapValid_ff[p], mapSlot_ff[p]);
			if (pinOpenDrain[p]) begin
				pinOut[p] = 1'b0;
				pinOutEn[p] = !nxt_pinOut[p];
			end else begin
				pinOut[p] = isBypass(mapValid_ff[p], mapSlot_ff[p]) ? nxt_pinOut[p] : pinOut_ff[p];
				pinOutEn[p] = globalRouteEnable && mapValid_ff[p] && slotOutEn[mapSlot_ff[p]];
			end
		end
	end

	// ****************************************
	// Pin input path
	// ****************************************
	logic [`PIN_COUNT-1:0] pinMeta_ff;
	logic [`PIN_COUNT-1:0] pinSync_ff;
	logic [`SLOT_COUNT-1:0] slotIn_ff;
	logic [`SLOT_COUNT-1:0] nxt_slotIn;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta_ff <= '0;
			pinSync_ff <= '0;
		end else begin
			pinMeta_ff <= pinIn;
			pinSync_ff <= pinMeta_ff;
		end
	end

	always_comb begin
		nxt_slotIn = '0;
		for (int p = 0; p < `PIN_COUNT; p++) begin
			if (mapValid_ff[p]) begin
				nxt_slotIn[mapSlot_ff[p]] = pinSync_ff[p];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slotIn_ff <= '0;
		end else begin
			slotIn_ff <= nxt_slotIn;
		end
	end

	assign slotIn = slotIn_ff;

	// ****************************************
	// Checks
	// ****************************************
	property p_cmp_b_async;
		@(posedge clk) disable iff (!rst_n)
		slotRouted[`SLOT_CMP_B_ASYNC] |-> $past(routeEnableLow[`BIT_CMP_B_ASYNC]);
	endproperty
	a_cmp_b_async: assert property (p_cmp_b_async) else $error("comparator B async routed while disabled");

	property p_cmp_sync;
		@(posedge clk) disable iff (!rst_n)
		(slotRouted[`SLOT_CMP_B_SYNC] |-> $past(routeEnableLow[`BIT_CMP_B_SYNC])) and
		(slotRouted[`SLOT_CMP_A_SYNC] |-> $past(routeEnableLow[`BIT_CMP_A_SYNC]));
	endproperty
	a_cmp_sync: assert property (p_cmp_sync) else $error("sync comparator routed while disabled");

	property p_cmp_a_async;
		@(posedge clk) disable iff (!rst_n)
		!$past(routeEnableLow[`BIT_CMP_A_ASYNC]) |-> !slotRouted[`SLOT_CMP_A_ASYNC];
	endproperty
	a_cmp_a_async: assert property (p_cmp_a_async) else $error("comparator A async routed while disabled");

	property p_serial_fixed;
		@(posedge clk) disable iff (!rst_n)
		$past(routeEnableLow[`BIT_ASYNC_SERIAL]) |->
			isSlot(mapValid_ff[`PIN_SERIAL_TX], mapSlot_ff[`PIN_SERIAL_TX], `SLOT_TX) &&
			isSlot(mapValid_ff[`PIN_SERIAL_RX], mapSlot_ff[`PIN_SERIAL_RX], `SLOT_RX);
	endproperty
	a_serial_fixed: assert property (p_serial_fixed) else $error("serial port not on its fixed pins");

	property p_spi_b_fixed;
		@(posedge clk) disable iff (!rst_n)
		$past(routeEnableHigh[`BIT_SPI_B]) |->
			isSlot(mapValid_ff[`PIN_SPI_B_SCK], mapSlot_ff[`PIN_SPI_B_SCK], `SLOT_SPI_B_SCK) &&
			isSlot(mapValid_ff[`PIN_SPI_B_MOSI], mapSlot_ff[`PIN_SPI_B_MOSI], `SLOT_SPI_B_MOSI);
	endproperty
	a_spi_b_fixed: assert property (p_spi_b_fixed) else $error("SPI B not on its fixed pins");

	property p_spi_b_sel;
		@(posedge clk) disable iff (!rst_n)
		slotRouted[`SLOT_SPI_B_SEL] |-> $past(spiBFourWire) && $past(routeEnableHigh[`BIT_SPI_B]);
	endproperty
	a_spi_b_sel: assert property (p_spi_b_sel) else $error("SPI B select routed in three-wire mode");

	property p_cap_reserved;
		@(posedge clk) disable iff (!rst_n)
		$past(capCount) == `CAP_COUNT_RESERVED |-> !slotRouted[`SLOT_CAP0];
	endproperty
	a_cap_reserved: assert property (p_cap_reserved) else $error("reserved capture count routed outputs");

	property p_no_drive_disabled;
		@(posedge clk) disable iff (!rst_n)
		!globalRouteEnable |-> pinOutEn == '0;
	endproperty
	a_no_drive_disabled: assert property (p_no_drive_disabled) else $error("pin driven while crossbar disabled");

	property p_twowire_od;
		@(posedge clk) disable iff (!rst_n)
		globalRouteEnable && slotRouted[`SLOT_SDA] |-> pinOpenDrain != '0 && (pinOut & pinOpenDrain) == '0;
	endproperty
	a_twowire_od: assert property (p_twowire_od) else $error("two-wire pin not open-drain");

	property p_track;
		@(posedge clk) disable iff (!rst_n)
		$past(want) != $past(want, 2) |-> (slotRouted & ~$past(want)) == '0;
	endproperty
	a_track: assert property (p_track) else $error("allocation did not follow registers");

	property p_spi_a_sel;
		@(posedge clk) disable iff (!rst_n)
		slotRouted[`SLOT_SPI_A_SEL] |-> $past(spiAFourWire) && $past(routeEnableLow[`BIT_SPI_A]);
	endproperty
	a_spi_a_sel: assert property (p_spi_a_sel) else $error("SPI A select routed in three-wire mode");

	property p_sys_clock;
		@(posedge clk) disable iff (!rst_n)
		slotRouted[`SLOT_SYS_CLOCK] |-> $past(routeEnableLow[`BIT_SYS_CLOCK]);
	endproperty
	a_sys_clock: assert property (p_sys_clock) else $error("system clock routed while disabled");
endmodule
`default_nettype wire

// *** hw/route_defines.svh ***
// Constants for the peripheral route-enable block.
// Assumes inclusion by bare name from the design files.
`ifndef ROUTE_DEFINES_SVH
`define ROUTE_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define ROUTE_ADDR_LOW 8'he1
`define ROUTE_ADDR_HIGH 8'he2
`define ROUTE_RESET_LOW 8'h00
`define ROUTE_RESET_HIGH 8'h00
`define ROUTE_HIGH_WMASK 8'h7f

// ****************************************
// Low register fields
// ****************************************
`define BIT_CMP_B_ASYNC 7
`define BIT_CMP_B_SYNC 6
`define BIT_CMP_A_ASYNC 5
`define BIT_CMP_A_SYNC 4
`define BIT_SYS_CLOCK 3
`define BIT_TWOWIRE 2
`define BIT_SPI_A 1
`define BIT_ASYNC_SERIAL 0

// ****************************************
// High register fields
// ****************************************
`define BIT_UNUSED_HIGH 7
`define BIT_SPI_B 6
`define BIT_TIMER_B 5
`define BIT_TIMER_A 4
`define BIT_COUNTER_EXT 3
`define CAP_COUNT_MSB 2
`define CAP_COUNT_LSB 0
`define CAP_COUNT_RESERVED 3'h7

// ****************************************
// Pins, lowest first; fixed locations
// ****************************************
`define PIN_COUNT 15
`define PIN_SERIAL_TX 4
`define PIN_SERIAL_RX 5
`define PIN_SPI_B_SCK 8
`define PIN_SPI_B_MISO 9
`define PIN_SPI_B_MOSI 10
`define PIN_SPI_B_SEL 11

// ****************************************
// Function slots in priority order
// ****************************************
`define SLOT_COUNT 26
`define SLOT_TX 5'h00
`define SLOT_RX 5'h01
`define SLOT_SPI_B_SCK 5'h02
`define SLOT_SPI_B_MISO 5'h03
`define SLOT_SPI_B_MOSI 5'h04
`define SLOT_SPI_B_SEL 5'h05
`define SLOT_FIRST_FLOAT 6
`define SLOT_SPI_A_SCK 6
`define SLOT_SPI_A_MISO 7
`define SLOT_SPI_A_MOSI 8
`define SLOT_SPI_A_SEL 9
`define SLOT_SDA 10
`define SLOT_SCL 11
`define SLOT_CMP_A_SYNC 12
`define SLOT_CMP_A_ASYNC 13
`define SLOT_CMP_B_SYNC 14
`define SLOT_CMP_B_ASYNC 15
`define SLOT_SYS_CLOCK 16
`define SLOT_CAP0 17
`define CAP_MODULES 6
`define SLOT_COUNTER_EXT 23
`define SLOT_TIMER_A 24
`define SLOT_TIMER_B 25

`endif

// *** hw/route_pkg.sv ***
// Types shared by the route-enable block.
// Assumes route_defines.svh is compiled alongside.
`default_nettype none
package route_pkg;
	typedef logic [4:0] slot_idx_t;
	typedef logic [7:0] sfr_byte_t;
endpackage
`default_nettype wire

// *** hw/route_regs.sv ***
// The two route-enable special function registers.
// Assumes a single-cycle SFR bus on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "route_defines.svh"

module route_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// SFR bus
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	output logic [7:0] sfrRdData,
	// Register contents
	output logic [7:0] routeEnableLow,
	output logic [7:0] routeEnableHigh
);
	route_pkg::sfr_byte_t low_ff;
	route_pkg::sfr_byte_t high_ff;
	route_pkg::sfr_byte_t rd_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_ff <= `ROUTE_RESET_LOW;
		end else if (sfrWrEn && sfrAddr == `ROUTE_ADDR_LOW) begin
			low_ff <= sfrWrData;
		end
	end

	// Unused top bit never stores, so it always reads zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			high_ff <= `ROUTE_RESET_HIGH;
		end else if (sfrWrEn && sfrAddr == `ROUTE_ADDR_HIGH) begin
			high_ff <= sfrWrData & `ROUTE_HIGH_WMASK;
		end
	end

	// Unmapped addresses read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ff <= 8'h00;
		end else if (sfrRdEn) begin
			case (sfrAddr)
				`ROUTE_ADDR_LOW: rd_ff <= low_ff;
				`ROUTE_ADDR_HIGH: rd_ff <= high_ff;
				default: rd_ff <= 8'h00;
			endcase
		end
	end

	assign sfrRdData = rd_ff;
	assign routeEnableLow = low_ff;
	assign routeEnableHigh = high_ff;

	property p_high_top_zero;
		@(posedge clk) disable iff (!rst_n)
		sfrRdEn && sfrAddr == `ROUTE_ADDR_HIGH |=> !sfrRdData[`BIT_UNUSED_HIGH];
	endproperty
	a_high_top_zero: assert property (p_high_top_zero) else $error("unused high bit read as one");
endmodule
`default_nettype wire

// *** test/periph_pin_model.sv ***
// Pad-side model of the port pins around the route block.
// Assumes routed two-wire pins have an external pull-up.
`timescale 1ns/1ps
`default_nettype none

module periph_pin_model (
	// From the route block
	input wire logic [14:0] pinOut,
	input wire logic [14:0] pinOutEn,
	input wire logic [14:0] pinOpenDrain,
	// Level driven from outside on free pins
	input wire logic [14:0] extIn,
	// Back to the route block
	output logic [14:0] pinIn
);
	// ****************************************
	// Pad levels
	// ****************************************
	// Driven pins read their own output, released open-drain pins float high, others follow the outside world
	always_comb begin
		for (int p = 0; p < 15; p++) begin
			if (pinOutEn[p])
				pinIn[p] = pinOut[p];
			else
				pinIn[p] = pinOpenDrain[p] | extIn[p];
		end
	end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the crossbar route-enable block.
// Assumes route_defines.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "route_defines.svh"

module testbench;
	logic clk = 0;
	logic rst_n = 0;
	logic [7:0] sfrAddr = 8'h00;
	logic [7:0] sfrWrData = 8'h00;
	logic sfrWrEn = 0;
	logic sfrRdEn = 0;
	logic [7:0] sfrRdData;
	logic globalRouteEnable = 0;
	logic [14:0] pinSkipMask = 15'h0000;
	logic spiAFourWire = 0;
	logic spiBFourWire = 0;
	logic [25:0] slotOut = 26'h0000000;
	logic [25:0] slotOutEn = 26'h0000000;
	logic [25:0] slotIn;
	logic [25:0] slotRouted;
	logic [14:0] pinIn;
	logic [14:0] pinOut;
	logic [14:0] pinOutEn;
	logic [14:0] pinOpenDrain;
	logic [14:0] extIn = 15'h0000;
	int n_errors = 0;
	int samples_checked = 0;
	int cyc = 0;

	// ****************************************
	// Design and pad model
	// ****************************************
	crossbar_peripheral_route_enables u_dut (
		.clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
		.sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
		.globalRouteEnable(globalRouteEnable), .pinSkipMask(pinSkipMask),
		.spiAFourWire(spiAFourWire), .spiBFourWire(spiBFourWire),
		.slotOut(slotOut), .slotOutEn(slotOutEn), .slotIn(slotIn),
		.slotRouted(slotRouted), .pinIn(pinIn), .pinOut(pinOut),
		.pinOutEn(pinOutEn), .pinOpenDrain(pinOpenDrain)
	);

	periph_pin_model u_pads (
		.pinOut(pinOut), .pinOutEn(pinOutEn), .pinOpenDrain(pinOpenDrain),
		.extIn(extIn), .pinIn(pinIn)
	);

	// ****************************************
	// Clock and hang guard
	// ****************************************
	always #12.5 clk = ~clk;

	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			stop_test();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Mapping follows a write two edges later; three leaves margin
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = 1;
		@(negedge clk);
		sfrWrEn = 0;
		wait_n(3);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(negedge clk);
		sfrAddr = a;
		sfrRdEn = 1;
		@(negedge clk);
		sfrRdEn = 0;
		chk(nm, {24'h0, sfrRdData}, {24'h0, e});
	endtask

	task automatic stop_test();
		$display("Checked %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		rd(8'he1, 8'h00, "low reset");
		rd(8'he2, 8'h00, "high reset");
		chk("pinOutEn reset", {17'h0, pinOutEn}, 32'h0);
		wr(8'he1, 8'ha5);
		wr(8'he2, 8'hff);
		wr(8'h33, 8'hff);
		rd(8'he1, 8'ha5, "low rw");
		rd(8'he2, 8'h7f, "high bit7");
		rd(8'h33, 8'h00, "unmapped");
		$display("t_regs done");
	endtask

	task automatic t_serial();
		wr(8'he2, 8'h00);
		wr(8'he1, 8'h01);
		globalRouteEnable = 1;
		slotOutEn = 26'h0000001;
		slotOut = 26'h0000001;
		extIn = 15'h0020;
		wait_n(4);
		chk("serial slots", {6'h0, slotRouted}, 32'h3);
		chk("tx pin drive", {17'h0, pinOutEn}, 32'h10);
		chk("tx pin value", {31'h0, pinOut[`PIN_SERIAL_TX]}, 32'h1);
		chk("rx pin input", {31'h0, slotIn[1]}, 32'h1);
		globalRouteEnable = 0;
		#1;
		chk("global off", {17'h0, pinOutEn}, 32'h0);
		chk("map kept", {6'h0, slotRouted}, 32'h3);
		globalRouteEnable = 1;
		$display("t_serial done");
	endtask

	task automatic t_spi_b();
		slotOutEn = '1;
		slotOut = '0;
		extIn = 15'h0000;
		wr(8'he1, 8'h00);
		wr(8'he2, 8'h40);
		chk("spib 3w slots", {6'h0, slotRouted}, 32'h1c);
		chk("spib 3w pins", {17'h0, pinOutEn}, 32'h700);
		spiBFourWire = 1;
		wait_n(3);
		chk("spib 4w slots", {6'h0, slotRouted}, 32'h3c);
		chk("spib 4w pins", {17'h0, pinOutEn}, 32'hf00);
		spiBFourWire = 0;
		$display("t_spi_b done");
	endtask

	// One low-register function at a time lands on the lowest pins
	task automatic t_low_bits();
		logic [25:0] sm[8];
		logic [14:0] pm[8];
		sm = '{26'h0, 26'h1c0, 26'hc00, 26'h10000, 26'h1000, 26'h2000, 26'h4000, 26'h8000};
		pm = '{15'h0, 15'h7, 15'h3, 15'h1, 15'h1, 15'h1, 15'h1, 15'h1};
		slotOutEn = '1;
		slotOut = '0;
		wr(8'he2, 8'h00);
		for (int b = 1; b < 8; b++) begin
			wr(8'he1, 8'h01 << b);
			chk($sformatf("low bit %0d slots", b), {6'h0, slotRouted}, {6'h0, sm[b]});
			chk($sformatf("low bit %0d pins", b), {17'h0, pinOutEn}, {17'h0, pm[b]});
			chk("open drain", {17'h0, pinOpenDrain}, (b == 2) ? 32'h3 : 32'h0);
			// Async comparators and clock show a new level before any edge
			slotOut = '1;
			#1;
			chk("bypass pin0", {31'h0, pinOut[0]}, (b == 3 || b == 5 || b == 7) ? 32'h1 : 32'h0);
			chk("od release", {17'h0, pinOutEn}, (b == 2) ? 32'h0 : {17'h0, pm[b]});
			slotOut = '0;
		end
		$display("t_low_bits done");
	endtask

	task automatic t_high_bits();
		wr(8'he1, 8'h00);
		for (int b = 3; b < 6; b++) begin
			wr(8'he2, 8'h01 << b);
			chk($sformatf("high bit %0d", b), {6'h0, slotRouted}, 32'h1 << (b + 20));
		end
		for (int n = 0; n < 8; n++) begin
			wr(8'he2, n[7:0]);
			chk($sformatf("capture %0d", n), {6'h0, slotRouted}, (n == 7) ? 32'h0 : (((32'h1 << n) - 1) << 17));
		end
		$display("t_high_bits done");
	endtask

	// Serial fixed on 4,5, pin 0 skipped, select wire shifts comparator
	task automatic t_priority();
		wr(8'he2, 8'h00);
		pinSkipMask = 15'h0001;
		slotOutEn = 26'h0001000;
		slotOut = 26'h0001000;
		wr(8'he1, 8'h13);
		chk("cmp 3w pin", {17'h0, pinOutEn}, 32'h40);
		chk("cmp 3w value", {31'h0, pinOut[6]}, 32'h1);
		spiAFourWire = 1;
		wait_n(3);
		chk("cmp 4w pin", {17'h0, pinOutEn}, 32'h80);
		chk("spia 4w slots", {6'h0, slotRouted}, 32'h13c3);
		$display("t_priority done");
	endtask

	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst_n = 1;
		t_regs();
		t_serial();
		t_spi_b();
		t_low_bits();
		t_high_bits();
		t_priority();
		stop_test();
	end
endmodule
`default_nettype wire
